// ---- include/cgm_pkg.sv ----
// package: register map, field layout and mode types of the clock mode slice
package cgm_pkg;

	localparam int ADDR_W = 4;
	// register byte addresses (no offsets printed; chosen locally)
	localparam logic [ADDR_W-1:0] ADDR_PLL_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

	// pll_loop_control fields
	localparam int LOSS_OF_LOCK_IRQ_ENABLE_BIT = 7;
	localparam int PLL_SELECT_BIT = 6;
	localparam int CME_BIT = 5;
	localparam int VCO_MULTIPLIER_LO = 0;
	localparam int VCO_MULTIPLIER_W = 4;
	localparam logic [7:0] PLL_CTRL_RST = 8'h00;
	localparam logic [7:0] PLL_CTRL_WMASK = 8'he0 | 8'h0f;

	// clock_control fields (own register)
	localparam int CLOCK_SOURCE_SELECT_LO = 6;
	localparam int REF_SELECT_BIT = 5;
	localparam int REF_DIVIDER_LO = 2;
	localparam int LP_BIT = 1;
	localparam int EXT_REF_OUTPUT_ENABLE_BIT = 0;
	localparam logic [7:0] CLK_CTRL_RST = 8'h20;

	// status fields
	localparam int LOST_LOCK_FLAG_BIT = 7;
	localparam int LOCK_BIT = 6;
	localparam int PLLST_BIT = 5;
	localparam int IREFST_BIT = 4;
	localparam int CLOCK_MODE_STATUS_LO = 2;

	localparam logic [1:0] CLOCK_SOURCE_SELECT_LOOP = 2'h0;
	localparam logic [1:0] CLOCK_SOURCE_SELECT_INT = 2'h1;
	localparam logic [1:0] CLOCK_SOURCE_SELECT_EXT = 2'h2;
	localparam logic [1:0] CLOCK_MODE_STATUS_PLL = 2'h3;
	localparam logic [2:0] REF_DIVIDER_NONE = 3'h0;

	localparam logic [3:0] VCO_MULTIPLIER_MAX_CODE = 4'ha;
	localparam logic [5:0] VCO_MULTIPLIER_STEP = 6'h04;
	localparam logic [5:0] MULT_MAX = 6'h28;
	localparam logic [10:0] FLL_FACTOR = 11'h400;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// divided reference windows, in millihertz so no bound is rounded
	localparam int FLL_REF_MIN_MILLIHZ = 31250000;
	localparam int FLL_REF_MAX_MILLIHZ = 39062500;
	localparam int PLL_REF_MIN_MILLIHZ = 1000000000;
	localparam int PLL_REF_MAX_MILLIHZ = 2000000000;

	// synchroniser depth for the status view
	localparam int SYNC_STAGES = 2;

	typedef enum logic [3:0] {
		CGM_FEI,
		CGM_FEE,
		CGM_FBI,
		CGM_FBE,
		CGM_PEE,
		CGM_PBE,
		CGM_BLPI,
		CGM_BYPASSED_LOW_POWER_EXTERNAL
	} cgm_mode_t;

	typedef struct packed {
		logic [1:0] clock_source_select;
		logic ref_select;
		logic pll_select;
		logic lp;
		logic debug_en;
	} cgm_req_t;

	typedef struct packed {
		logic fll_en;
		logic pll_en;
		logic fll_lowpower;
		logic pll_lowpower;
		logic debug_from_dco_half;
		logic [1:0] out_src;
	} cgm_ctl_t;

endpackage

// ---- hw/cgm_mode_dec.sv ----
// mode decoder: requested control bits to operating mode and loop enables
`timescale 1ns/1ps
`default_nettype none

module cgm_mode_dec (
	input wire cgm_pkg::cgm_req_t req_i,
	output cgm_pkg::cgm_mode_t mode_o,
	output cgm_pkg::cgm_ctl_t ctl_o
);

	wire ext_ok;
	wire lp_eff;
	cgm_pkg::cgm_mode_t mode_w;
	cgm_pkg::cgm_ctl_t ctl_w;

	// active debug forces a low-power request back to a bypassed mode
	assign lp_eff = req_i.lp & ~req_i.debug_en;
	assign ext_ok = ~req_i.ref_select;

	always_comb begin
		mode_w = cgm_pkg::CGM_FEI;
		if (req_i.clock_source_select == cgm_pkg::CLOCK_SOURCE_SELECT_LOOP) begin
			if (req_i.ref_select) begin
				mode_w = cgm_pkg::CGM_FEI; // R8
			end else if (req_i.pll_select) begin
				mode_w = cgm_pkg::CGM_PEE; // R13
			end else begin
				mode_w = cgm_pkg::CGM_FEE; // R10
			end
		end else if (req_i.clock_source_select == cgm_pkg::CLOCK_SOURCE_SELECT_INT) begin
			if (lp_eff) begin
				mode_w = cgm_pkg::CGM_BLPI;
			end else begin
				mode_w = cgm_pkg::CGM_FBI; // R11
			end
		end else if (ext_ok) begin
			if (lp_eff) begin
				mode_w = cgm_pkg::CGM_BYPASSED_LOW_POWER_EXTERNAL;
			end else if (req_i.pll_select) begin
				mode_w = cgm_pkg::CGM_PBE;
			end else begin
				mode_w = cgm_pkg::CGM_FBE; // R12
			end
		end else begin
			// external bypass with internal reference: treat as internal
			mode_w = lp_eff ? cgm_pkg::CGM_BLPI : cgm_pkg::CGM_FBI;
		end
	end

	always_comb begin
		ctl_w = '0;
		// R2: the unselected loop is off in every mode
		ctl_w.pll_en = req_i.pll_select;
		ctl_w.fll_en = ~req_i.pll_select;
		if (mode_w == cgm_pkg::CGM_BLPI || mode_w == cgm_pkg::CGM_BYPASSED_LOW_POWER_EXTERNAL) begin
			ctl_w.pll_en = 1'b0;
			ctl_w.fll_en = 1'b0;
		end
		ctl_w.pll_lowpower = ~ctl_w.pll_en; // R16
		// R15: pll modes keep the dco open loop only for debug
		ctl_w.debug_from_dco_half = req_i.pll_select & req_i.debug_en;
		ctl_w.fll_lowpower = ~ctl_w.fll_en & ~ctl_w.debug_from_dco_half; // R15
		case (mode_w)
			cgm_pkg::CGM_FEI,
			cgm_pkg::CGM_FEE: ctl_w.out_src = cgm_pkg::CLOCK_SOURCE_SELECT_LOOP;
			cgm_pkg::CGM_PEE: ctl_w.out_src = cgm_pkg::CLOCK_MODE_STATUS_PLL; // R14
			cgm_pkg::CGM_FBI,
			cgm_pkg::CGM_BLPI: ctl_w.out_src = cgm_pkg::CLOCK_SOURCE_SELECT_INT;
			default: ctl_w.out_src = cgm_pkg::CLOCK_SOURCE_SELECT_EXT;
		endcase
	end

	assign mode_o = mode_w;
	assign ctl_o = ctl_w;

endmodule

`default_nettype wire

// ---- hw/cgm_ctrl.sv ----
// top: ahb-lite register slice for clock mode, pll factor and monitors
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: interrupt request when irq enable set and lost-lock flag set.
// R2: pll_select clear disables PLL; set disables FLL, in all modes.
// R3: monitor enabled: loss of external reference raises a reset request.
// R4: software sets monitor only with external mode or ref output on.
// R5: software keeps range selection fixed while monitor is enabled.
// R6: multiplier codes 1 to 10 give factor four times the code.
// R7: code 0 reserved; codes 11 to 15 act as factor 40.
// R8: after reset the mode is FLL engaged internal.
// R9: FLL modes lock to 1024 times the divided reference.
// R10: FLL engaged external; divided reference 31.25 to 39.0625 kHz.
// R11: FLL bypassed internal: output from internal reference, FLL runs.
// R12: FLL bypassed external: output from external reference, FLL runs.
// R13: PLL engaged external; divided reference 1 to 2 MHz.
// R14: PLL engaged external output is PLL at multiplier times reference.
// R15: PLL engaged, debug: debug clock is DIGITALLY_CONTROLLED_OSCILLATOR halved, else FLL low power.
// R16: FLL modes: debug clock from FLL, PLL held in low power.
// R17: FLL bypassed external tolerates reference above maximum briefly.
// R18: lost-lock flag sticky; cleared by reset or writing one.
// R19: mode status reports source after synchronisation.
// R20: source hand-over keeps previous source while new clock unavailable.
module cgm_ctrl (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic LOCK_LOST_I,
	input wire logic LOCKED_I,
	input wire logic EXT_CLK_LOST_I,
	input wire logic EXT_CLK_READY_I,
	input wire logic INT_CLK_READY_I,
	input wire logic DEBUG_EN_I,
	output logic LOL_IRQ_O,
	output logic CLK_MON_RESET_REQ_O,
	output logic FLL_EN_O,
	output logic PLL_EN_O,
	output logic FLL_LOWPOWER_O,
	output logic PLL_LOWPOWER_O,
	output logic DEBUG_CLK_DCO_HALF_O,
	output logic [1:0] OUT_SRC_SEL_O,
	output logic [2:0] REF_DIVIDER_O,
	output logic [5:0] PLL_MULT_O,
	output logic [10:0] FLL_MULT_O,
	output logic EXT_REF_OUTPUT_EN_O
);

	////////////////////////////////////////////////////////////////////////
	// reset release and input synchronisers

	logic [1:0] rst_sync_q;
	wire rst_n;

	// assert at once, release only after two clean edges
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	localparam int NSYNC = 6;
	wire [NSYNC-1:0] async_in;
	wire [NSYNC-1:0] sync_out;
	assign async_in = {DEBUG_EN_I, INT_CLK_READY_I, EXT_CLK_READY_I,
		EXT_CLK_LOST_I, LOCKED_I, LOCK_LOST_I};

	// status inputs come from the analog clock domains
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			logic s1_q;
			logic s2_q;
			always_ff @(posedge CLK_I or negedge rst_n) begin
				if (!rst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
				end else begin
					s1_q <= async_in[gi];
					s2_q <= s1_q;
				end
			end
			// only the second stage leaves the synchroniser
			assign sync_out[gi] = s2_q;
		end
	endgenerate

	wire lock_lost_s;
	wire locked_s;
	wire ext_lost_s;
	wire ext_rdy_s;
	wire int_rdy_s;
	wire dbg_s;
	assign lock_lost_s = sync_out[0];
	assign locked_s = sync_out[1];
	assign ext_lost_s = sync_out[2];
	assign ext_rdy_s = sync_out[3];
	assign int_rdy_s = sync_out[4];
	assign dbg_s = sync_out[5];

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait state, always OKAY

	logic wr_pend_q;
	logic rd_pend_q;
	logic [cgm_pkg::ADDR_W-1:0] addr_q;
	// only the low address bits decode; upper bits alias
	wire take;
	assign take = HSEL_I & HREADY_I & (HTRANS_I == cgm_pkg::HTRANS_NONSEQ);

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= '0;
		end else begin
			wr_pend_q <= take & HWRITE_I;
			rd_pend_q <= take & ~HWRITE_I;
			if (take) begin
				addr_q <= HADDR_I[cgm_pkg::ADDR_W-1:0];
			end
		end
	end

	// every register answers at once, so no wait state is ever needed
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;

	wire wr_pll;
	wire wr_clk;
	wire wr_sts;
	assign wr_pll = wr_pend_q & (addr_q == cgm_pkg::ADDR_PLL_CTRL);
	assign wr_clk = wr_pend_q & (addr_q == cgm_pkg::ADDR_CLK_CTRL);
	assign wr_sts = wr_pend_q & (addr_q == cgm_pkg::ADDR_STATUS);

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic [7:0] pll_ctrl_q;
	logic [7:0] clk_ctrl_q;
	logic lost_lock_flag_q;

	// bit 4 of the pll register is not stored and reads zero
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pll_ctrl_q <= cgm_pkg::PLL_CTRL_RST;
			clk_ctrl_q <= cgm_pkg::CLK_CTRL_RST; // R8
		end else begin
			if (wr_pll) begin
				pll_ctrl_q <= HWDATA_I[7:0] & cgm_pkg::PLL_CTRL_WMASK;
			end
			if (wr_clk) begin
				clk_ctrl_q <= HWDATA_I[7:0];
			end
		end
	end

	// set wins over a write-one clear in the same cycle
	// clear needs the flag already set, so a stale write-one is harmless
	wire lost_lock_flag_clr;
	assign lost_lock_flag_clr = wr_sts & HWDATA_I[cgm_pkg::LOST_LOCK_FLAG_BIT] & lost_lock_flag_q;
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			lost_lock_flag_q <= 1'b0;
		end else if (lock_lost_s) begin
			lost_lock_flag_q <= 1'b1; // R18
		end else if (lost_lock_flag_clr) begin
			lost_lock_flag_q <= 1'b0; // R18
		end
	end

	// field views of the two control registers
	wire loss_of_lock_irq_enable;
	wire pll_select;
	wire clock_monitor_enable;
	wire [3:0] vco_multiplier;
	wire [1:0] clock_source_select;
	wire ref_select;
	wire [2:0] ref_divider;
	wire lp;
	wire ext_ref_output_enable;
	assign loss_of_lock_irq_enable = pll_ctrl_q[cgm_pkg::LOSS_OF_LOCK_IRQ_ENABLE_BIT];
	assign pll_select = pll_ctrl_q[cgm_pkg::PLL_SELECT_BIT];
	assign clock_monitor_enable = pll_ctrl_q[cgm_pkg::CME_BIT];
	assign vco_multiplier = pll_ctrl_q[cgm_pkg::VCO_MULTIPLIER_LO +: cgm_pkg::VCO_MULTIPLIER_W];
	assign clock_source_select = clk_ctrl_q[cgm_pkg::CLOCK_SOURCE_SELECT_LO +: 2];
	assign ref_select = clk_ctrl_q[cgm_pkg::REF_SELECT_BIT];
	assign ref_divider = clk_ctrl_q[cgm_pkg::REF_DIVIDER_LO +: 3];
	assign lp = clk_ctrl_q[cgm_pkg::LP_BIT];
	assign ext_ref_output_enable = clk_ctrl_q[cgm_pkg::EXT_REF_OUTPUT_ENABLE_BIT];

	////////////////////////////////////////////////////////////////////////
	// multiplication factors

	// reserved zero is passed as factor 0; codes above 10 saturate
	wire [5:0] mult_raw;
	wire [5:0] pll_mult;
	assign mult_raw = 6'(vco_multiplier) * cgm_pkg::VCO_MULTIPLIER_STEP; // R6
	assign pll_mult = (vco_multiplier > cgm_pkg::VCO_MULTIPLIER_MAX_CODE) ?
		cgm_pkg::MULT_MAX : mult_raw; // R7

	////////////////////////////////////////////////////////////////////////
	// mode decode and source hand-over

	cgm_pkg::cgm_req_t req;
	cgm_pkg::cgm_ctl_t ctl;

	assign req.clock_source_select = clock_source_select;
	assign req.ref_select = ref_select;
	assign req.pll_select = pll_select;
	assign req.lp = lp;
	assign req.debug_en = dbg_s;

	cgm_mode_dec u_dec (
		.req_i(req),
		.mode_o(),
		.ctl_o(ctl)
	);

	// a source switch only completes once the new clock is there
	wire src_avail;
	assign src_avail =
		(ctl.out_src == cgm_pkg::CLOCK_SOURCE_SELECT_INT) ? int_rdy_s :
		(ctl.out_src == cgm_pkg::CLOCK_SOURCE_SELECT_EXT) ? ext_rdy_s :
		(ctl.out_src == cgm_pkg::CLOCK_MODE_STATUS_PLL) ? locked_s :
		1'b1;

	logic [1:0] out_src_q;
	logic irefst_q;
	logic pllst_q;
	// reference status follows the select only once that reference runs
	wire ref_avail;
	assign ref_avail = ref_select ? int_rdy_s : ext_rdy_s;

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			out_src_q <= cgm_pkg::CLOCK_SOURCE_SELECT_LOOP;
			irefst_q <= 1'b1;
			pllst_q <= 1'b0;
		end else begin
			if (src_avail) begin
				out_src_q <= ctl.out_src; // R20
			end
			if (ref_avail) begin
				irefst_q <= ref_select;
			end
			pllst_q <= pll_select;
		end
	end

	// status view lags the applied selection by the sync depth
	logic [cgm_pkg::SYNC_STAGES*4-1:0] st_pipe_q;
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			st_pipe_q <= {cgm_pkg::SYNC_STAGES{cgm_pkg::CLOCK_SOURCE_SELECT_LOOP, 1'b1,
				1'b0}}; // R8
		end else begin
			st_pipe_q <= {st_pipe_q[cgm_pkg::SYNC_STAGES*4-5:0],
				out_src_q, irefst_q, pllst_q}; // R19
		end
	end

	wire [3:0] st_view;
	assign st_view = st_pipe_q[cgm_pkg::SYNC_STAGES*4-1 -: 4];

	////////////////////////////////////////////////////////////////////////
	// read mux

	wire [7:0] status_rd;
	assign status_rd = {lost_lock_flag_q, locked_s, st_view[0], st_view[1],
		st_view[3:2], 2'h0};

	// unmapped offsets read zero; no bus error is raised
	wire [7:0] rd_sel;
	assign rd_sel =
		(addr_q == cgm_pkg::ADDR_PLL_CTRL) ? pll_ctrl_q :
		(addr_q == cgm_pkg::ADDR_CLK_CTRL) ? clk_ctrl_q :
		(addr_q == cgm_pkg::ADDR_STATUS) ? status_rd :
		8'h00;

	assign HRDATA_O = rd_pend_q ? {24'h000000, rd_sel} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// outputs

	logic irq_q;
	logic mon_q;
	logic [5:0] pll_mult_q;
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
			mon_q <= 1'b0;
			pll_mult_q <= '0;
		end else begin
			irq_q <= loss_of_lock_irq_enable & lost_lock_flag_q; // R1
			// monitor only meaningful with external use; see R4 R5
			mon_q <= clock_monitor_enable & ext_lost_s; // R3
			pll_mult_q <= pll_mult; // R14
		end
	end

	// loop controls leave through flops, like the irq, monitor and pll factor outputs
	cgm_pkg::cgm_ctl_t ctl_q;
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= '{fll_en: 1'b1, pll_en: 1'b0, fll_lowpower: 1'b0,
				pll_lowpower: 1'b1, debug_from_dco_half: 1'b0,
				out_src: cgm_pkg::CLOCK_SOURCE_SELECT_LOOP}; // R8
		end else begin
			ctl_q <= ctl;
		end
	end

	assign LOL_IRQ_O = irq_q;
	assign CLK_MON_RESET_REQ_O = mon_q;
	assign FLL_EN_O = ctl_q.fll_en; // R2
	assign PLL_EN_O = ctl_q.pll_en; // R2
	assign FLL_LOWPOWER_O = ctl_q.fll_lowpower; // R15
	assign PLL_LOWPOWER_O = ctl_q.pll_lowpower; // R16
	assign DEBUG_CLK_DCO_HALF_O = ctl_q.debug_from_dco_half; // R15
	// the applied source, which lags the request until that clock runs
	assign OUT_SRC_SEL_O = out_src_q;
	// reference window checks are software's; no clamp here
	assign REF_DIVIDER_O = ref_divider; // R10 R13 R17
	assign PLL_MULT_O = pll_mult_q;
	// fixed factor: only the divided reference moves the fll output
	assign FLL_MULT_O = cgm_pkg::FLL_FACTOR; // R9
	assign EXT_REF_OUTPUT_EN_O = ext_ref_output_enable;

endmodule

`default_nettype wire

// ---- verif/cgm_ctrl_chk.sv ----
// checker: bus answer, loop enables, factors and monitor of cgm_ctrl
`timescale 1ns/1ps
`default_nettype none

module cgm_ctrl_chk (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic EXT_CLK_LOST_I,
	input wire logic CLK_MON_RESET_REQ_O,
	input wire logic FLL_EN_O,
	input wire logic PLL_EN_O,
	input wire logic PLL_LOWPOWER_O,
	input wire logic DEBUG_CLK_DCO_HALF_O,
	input wire logic [5:0] PLL_MULT_O,
	input wire logic [10:0] FLL_MULT_O
);

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	////////////////////////////////////////
	a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus stalled or errored");
	a_rdata_width: assert property (HRDATA_O[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_loop_excl: assert property (!(FLL_EN_O && PLL_EN_O))
		else $error("both loops enabled");
	a_pll_parked: assert property (!PLL_EN_O |-> PLL_LOWPOWER_O)
		else $error("idle pll not in low power");
	a_dco_half: assert property (DEBUG_CLK_DCO_HALF_O |-> PLL_EN_O)
		else $error("halved dco debug clock outside pll mode");
	a_fll_factor: assert property (FLL_MULT_O == cgm_pkg::FLL_FACTOR)
		else $error("fll factor wrong");
	// a reserved code must never leak a factor above forty
	a_pll_factor: assert property (
		PLL_MULT_O <= cgm_pkg::MULT_MAX && PLL_MULT_O[1:0] == 2'h0)
		else $error("pll factor off grid");
	a_mon_rise: assert property (
		$rose(CLK_MON_RESET_REQ_O) |-> $past(EXT_CLK_LOST_I, 3))
		else $error("monitor reset without lost clock");
	a_mon_fall: assert property (
		(!EXT_CLK_LOST_I)[*4] |=> !CLK_MON_RESET_REQ_O)
		else $error("monitor reset held without cause");

endmodule

bind cgm_ctrl cgm_ctrl_chk cgm_ctrl_chk_inst (
	.CLK_I(CLK_I), .RSTN_I(RSTN_I), .HRDATA_O(HRDATA_O),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.EXT_CLK_LOST_I(EXT_CLK_LOST_I),
	.CLK_MON_RESET_REQ_O(CLK_MON_RESET_REQ_O),
	.FLL_EN_O(FLL_EN_O), .PLL_EN_O(PLL_EN_O),
	.PLL_LOWPOWER_O(PLL_LOWPOWER_O),
	.DEBUG_CLK_DCO_HALF_O(DEBUG_CLK_DCO_HALF_O),
	.PLL_MULT_O(PLL_MULT_O), .FLL_MULT_O(FLL_MULT_O)
);

`default_nettype wire

// ---- verif/clock_gen_mode_pll_control_tb_top.sv ----
// testbench: bus-driven checks of mode selection, factors and monitors
`timescale 1ns/1ps
`default_nettype none

module clock_gen_mode_pll_control_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, src;
	logic [2:0] hsize = 3'h2, ref_divider_o, rdv;
	logic lock_lost = 1'b0, locked = 1'b0, ext_lost = 1'b0;
	logic ext_rdy = 1'b0, int_rdy = 1'b1, dbg = 1'b0;
	logic hready, hresp, irq, mon, fll_en, pll_en, fll_lp, pll_lp, digitally_controlled_oscillator, ero;
	logic [5:0] mult;
	logic [10:0] fmult;
	int failures = 0;
	int compares = 0;

	always #2.5 clk = ~clk;

	cgm_ctrl cgm_ctrl_inst (
		.CLK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .LOCK_LOST_I(lock_lost),
		.LOCKED_I(locked), .EXT_CLK_LOST_I(ext_lost),
		.EXT_CLK_READY_I(ext_rdy), .INT_CLK_READY_I(int_rdy),
		.DEBUG_EN_I(dbg), .LOL_IRQ_O(irq), .CLK_MON_RESET_REQ_O(mon),
		.FLL_EN_O(fll_en), .PLL_EN_O(pll_en), .FLL_LOWPOWER_O(fll_lp),
		.PLL_LOWPOWER_O(pll_lp), .DEBUG_CLK_DCO_HALF_O(digitally_controlled_oscillator),
		.OUT_SRC_SEL_O(src), .REF_DIVIDER_O(ref_divider_o), .PLL_MULT_O(mult),
		.FLL_MULT_O(fmult), .EXT_REF_OUTPUT_EN_O(ero)
	);

	////////////////////////////////////////
	task automatic finish_test();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// no wait state expected, but never assumed
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1) begin
			failures++;
			$display("unexpected at %0t: bus never ready", $time);
			finish_test();
		end
	endtask

	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {28'h0, a};
		htrans <= cgm_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// inputs pass two sync flops, then one or two register stages
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask

	task automatic wait_src(input logic [1:0] s);
		int n;
		n = 0;
		while (src !== s && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(32'(src), 32'(s));
		if (src !== s) finish_test();
	endtask

	function automatic logic [5:0] mult_of(input logic [3:0] c);
		return c == 4'h0 ? 6'h00 : c > 4'ha ? 6'h28 : {c, 2'b00};
	endfunction

	////////////////////////////////////////
	initial begin
		logic [31:0] r;
		r = $urandom(32'h1f06);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		rdchk(cgm_pkg::ADDR_PLL_CTRL, 32'h0);
		rdchk(cgm_pkg::ADDR_CLK_CTRL, 32'h20);
		rdchk(4'hc, 32'h0);
		rdchk(cgm_pkg::ADDR_STATUS, 32'h10);
		chk(32'({src, fll_en, pll_en, pll_lp}), 32'h05);
		chk(32'(fmult), 32'h400);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			r = $urandom;
			wr_code: xfer(1'b1, cgm_pkg::ADDR_PLL_CTRL, {r[31:5], c[4:0]});
			rdchk(cgm_pkg::ADDR_PLL_CTRL, {24'h0, r[7:5], 1'b0, c[3:0]});
			chk(32'(mult), 32'(mult_of(c[3:0])));
		end
		$display("test factor done");
		xfer(1'b1, cgm_pkg::ADDR_PLL_CTRL, 32'h05);
		xfer(1'b1, cgm_pkg::ADDR_CLK_CTRL, 32'h60);
		wait_src(cgm_pkg::CLOCK_SOURCE_SELECT_INT);
		chk(32'(fll_en), 32'h1);
		rdv = 3'($urandom_range(7, 1));
		xfer(1'b1, cgm_pkg::ADDR_CLK_CTRL, {24'h0, 3'b100, rdv, 2'b00});
		settle();
		chk(32'(src), 32'(cgm_pkg::CLOCK_SOURCE_SELECT_INT));
		ext_rdy <= 1'b1;
		wait_src(cgm_pkg::CLOCK_SOURCE_SELECT_EXT);
		chk(32'({fll_en, ref_divider_o, ero}), 32'({1'b1, rdv, 1'b0}));
		xfer(1'b0, cgm_pkg::ADDR_STATUS, 32'h0);
		chk(rd & 32'h0c, 32'h08);
		xfer(1'b1, cgm_pkg::ADDR_CLK_CTRL, {24'h0, 3'b000, rdv, 2'b01});
		wait_src(cgm_pkg::CLOCK_SOURCE_SELECT_LOOP);
		chk(32'({fll_en, pll_en, pll_lp, ero}), 32'hb);
		xfer(1'b1, cgm_pkg::ADDR_PLL_CTRL, 32'h45);
		settle();
		chk(32'(src), 32'(cgm_pkg::CLOCK_SOURCE_SELECT_LOOP));
		locked <= 1'b1;
		wait_src(cgm_pkg::CLOCK_MODE_STATUS_PLL);
		chk(32'({fll_en, pll_en, fll_lp, digitally_controlled_oscillator, mult}), 32'h194);
		dbg <= 1'b1;
		settle();
		chk(32'(digitally_controlled_oscillator), 32'h1);
		xfer(1'b0, cgm_pkg::ADDR_STATUS, 32'h0);
		chk(rd & 32'h2c, 32'h2c);
		dbg <= 1'b0;
		xfer(1'b1, cgm_pkg::ADDR_PLL_CTRL, 32'h05);
		wait_src(cgm_pkg::CLOCK_SOURCE_SELECT_LOOP);
		chk(32'({fll_en, pll_en, pll_lp}), 32'h5);
		$display("test modes done");
		lock_lost <= 1'b1;
		repeat (4) @(posedge clk);
		lock_lost <= 1'b0;
		settle();
		chk(32'(irq), 32'h0);
		xfer(1'b1, cgm_pkg::ADDR_STATUS, 32'h0);
		xfer(1'b0, cgm_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[7]), 32'h1);
		xfer(1'b1, cgm_pkg::ADDR_PLL_CTRL, 32'h85);
		settle();
		chk(32'(irq), 32'h1);
		xfer(1'b1, cgm_pkg::ADDR_STATUS, 32'h80);
		settle();
		chk(32'(irq), 32'h0);
		rdchk(cgm_pkg::ADDR_PLL_CTRL, 32'h85);
		$display("test lock loss done");
		ext_lost <= 1'b1;
		settle();
		chk(32'(mon), 32'h0);
		// monitor armed by its enable bit alone; the mode is not checked
		xfer(1'b1, cgm_pkg::ADDR_PLL_CTRL, 32'ha5);
		settle();
		chk(32'(mon), 32'h1);
		ext_lost <= 1'b0;
		settle();
		chk(32'(mon), 32'h0);
		$display("test monitor done");
		finish_test();
	end
endmodule

`default_nettype wire
